// ===== rtl/tick_pkg.sv
package tick_pkg;

  // ---------------------------------------------------------------
  // Bus geometry and answers
  // ---------------------------------------------------------------
  localparam int          DATA_W      = 32;
  localparam int          ADDR_W      = 8;
  localparam int          STRB_W      = DATA_W / 8;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_LIMIT = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CTRL  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_STAT  = 8'h0C;

  // ---------------------------------------------------------------
  // Field layout
  // ---------------------------------------------------------------
  localparam int CNT_W        = 8;
  localparam int SRC_W        = 2;
  localparam int DIV_W        = 4;
  localparam int CTRL_SRC_LSB = 0;
  localparam int CTRL_DIV_LSB = 4;
  localparam int CTRL_IEN_BIT = 8;
  localparam int STAT_FLG_BIT = 0;
  localparam int PRE_W        = 10;
  localparam int SRC_NUM      = 3;
  localparam int SYNC_STAGES  = 3;

  typedef enum logic [SRC_W-1:0] {
    SRC_LOW_POWER,
    SRC_EXT_REF,
    SRC_INT_REF,
    SRC_IDLE
  } source_e;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [CNT_W-1:0] COUNT_RST = 8'h00;
  localparam logic [CNT_W-1:0] LIMIT_RST = 8'h00;
  localparam source_e          SRC_RST   = SRC_LOW_POWER;
  localparam logic [DIV_W-1:0] DIV_RST   = 4'h0;
  localparam logic [DIV_W-1:0] DIV_OFF   = 4'h0;
  localparam logic [DIV_W-1:0] DEC_BASE  = 4'h8;

  // Division ratio: 1..7 binary 2^sel, 8..15 decimal steps
  function automatic logic [PRE_W-1:0] div_ratio(input logic [DIV_W-1:0] sel);
    logic [PRE_W-1:0] r;
    r = 10'h001;
    if (sel < DEC_BASE) begin
      r = PRE_W'(1) << sel;
    end else begin
      case (sel[2:0])
        3'h0:    r = 10'h001;
        3'h1:    r = 10'h00A;
        3'h2:    r = 10'h014;
        3'h3:    r = 10'h032;
        3'h4:    r = 10'h064;
        3'h5:    r = 10'h0C8;
        3'h6:    r = 10'h1F4;
        default: r = 10'h3E8;
      endcase
    end
    return r;
  endfunction

endpackage

// ===== rtl/tick_if.sv
`timescale 1ns/1ps
interface tick_if;
  import tick_pkg::*;

  logic             src_edge;  // Rising edge of chosen source
  logic [PRE_W-1:0] ratio;     // Division ratio
  logic             run;       // Prescaler enabled
  logic             clear;     // Restart prescaler
  logic             tick;      // Prescaler output pulse

  modport ctrl (output src_edge, ratio, run, clear, input tick);
  modport pre  (input src_edge, ratio, run, clear, output tick);
endinterface

// ===== rtl/tick_prescaler.sv
`timescale 1ns/1ps
module tick_prescaler (
  input  wire logic i_clk,    // System clock
  input  wire logic i_rst_b,  // Synchronous reset, active low
  tick_if.pre       bus       // Prescaler control and output
);
  import tick_pkg::*;

  logic [PRE_W-1:0] cnt_q;
  logic             tick_q;
  logic             last;

  assign last    = (cnt_q == (bus.ratio - PRE_W'(1)));
  assign bus.tick = tick_q;

  // ---------------------------------------------------------------
  // Divider state
  // ---------------------------------------------------------------
  // off while select zero
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      cnt_q <= '0;
    end else if (bus.clear || !bus.run) begin
      cnt_q <= '0;
    end else if (bus.src_edge) begin
      cnt_q <= last ? '0 : cnt_q + PRE_W'(1);
    end
  end

  // ---------------------------------------------------------------
  // Output pulse
  // ---------------------------------------------------------------
  // divide by ratio
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= bus.run && !bus.clear && bus.src_edge && last;
    end
  end
endmodule

// ===== rtl/periodic_tick_counter.sv
`timescale 1ns/1ps
// Functional notes
// - Count reads back as 8 bits; writes to it change nothing.
// - Count clears on reset, limit write, or changed source/divider write.
// - Count advances per prescaler pulse; on limit match returns zero, sets flag.
// - Limit zero sets the flag on every prescaler pulse.
// - Any limit write restarts prescaler and count at zero.
// - Reset leaves count zero, limit zero, prescaler off.
// - Reset selects the low-power oscillator as counting source.
// - Prescaler idles while divider select is zero, runs otherwise.
// - Source select picks low-power, external or internal reference clock.
// - Writing a different source restarts prescaler and count.
// - Divider select offers binary and decimal division ratios.
// - Software-enabled interrupt signals the periodic flag.
module periodic_tick_counter (
  input  wire logic                           i_clk,                // 40 MHz clock
  input  wire logic                           i_rst_b,              // Sync reset, low
  input  wire logic                           i_low_power_osc_clock, // Source 0 pin
  input  wire logic                           i_external_ref_clock, // Source 1 pin
  input  wire logic                           i_internal_ref_clock, // Source 2 pin
  input  wire logic [tick_pkg::ADDR_W-1:0]    i_awaddr,             // Write address
  input  wire logic                           i_awvalid,            // Write addr valid
  output logic                                o_awready,            // Write addr ready
  input  wire logic [tick_pkg::DATA_W-1:0]    i_wdata,              // Write data
  input  wire logic [tick_pkg::STRB_W-1:0]    i_wstrb,              // Byte strobes
  input  wire logic                           i_wvalid,             // Write data valid
  output logic                                o_wready,             // Write data ready
  output logic [1:0]                          o_bresp,              // Write response
  output logic                                o_bvalid,             // Response valid
  input  wire logic                           i_bready,             // Response ready
  input  wire logic [tick_pkg::ADDR_W-1:0]    i_araddr,             // Read address
  input  wire logic                           i_arvalid,            // Read addr valid
  output logic                                o_arready,            // Read addr ready
  output logic [tick_pkg::DATA_W-1:0]         o_rdata,              // Read data
  output logic [1:0]                          o_rresp,              // Read response
  output logic                                o_rvalid,             // Read data valid
  input  wire logic                           i_rready,             // Read data ready
  output logic                                o_irq                 // Interrupt, high
);
  import tick_pkg::*;

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic                 aw_held_q;
  logic [ADDR_W-1:0]    aw_addr_q;
  logic                 w_held_q;
  logic [DATA_W-1:0]    w_data_q;
  logic [STRB_W-1:0]    w_strb_q;
  logic                 bvalid_q;
  logic [1:0]           bresp_q;
  logic                 rvalid_q;
  logic [1:0]           rresp_q;
  logic [DATA_W-1:0]    rdata_q;

  logic [CNT_W-1:0]     count_q;
  logic [CNT_W-1:0]     limit_q;
  source_e              src_q;
  logic [DIV_W-1:0]     div_q;
  logic                 ien_q;
  logic                 flag_q;

  logic [SRC_NUM-1:0]   pins;
  logic [SYNC_STAGES-1:0] sync_q [SRC_NUM];
  logic [SRC_NUM-1:0]   level_q;
  logic                 sel_level;
  logic                 prev_q;

  logic                 wr_go;
  logic                 wr_limit;
  logic                 wr_ctrl;
  logic                 wr_stat;
  logic                 wr_hit;
  logic [DATA_W-1:0]    ctrl_word;
  logic [DATA_W-1:0]    ctrl_new;
  logic [DATA_W-1:0]    limit_new;
  logic [DATA_W-1:0]    stat_new;
  source_e              src_new;
  logic [DIV_W-1:0]     div_new;
  logic                 cfg_change;
  logic                 restart;
  logic                 match;
  logic                 flag_set;
  logic                 flag_clr;
  logic [DATA_W-1:0]    rd_word;
  logic                 rd_hit;

  tick_if tick_bus ();

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Merge bus data into a word under byte strobes
  function automatic logic [DATA_W-1:0] apply_strb(
    input logic [DATA_W-1:0] old_w,
    input logic [DATA_W-1:0] new_w,
    input logic [STRB_W-1:0] strb
  );
    logic [DATA_W-1:0] res;
    res = old_w;
    for (int b = 0; b < STRB_W; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // ---------------------------------------------------------------
  // Source pin synchronisers
  // ---------------------------------------------------------------
  assign pins = {i_internal_ref_clock, i_external_ref_clock, i_low_power_osc_clock};

  for (genvar s = 0; s < SRC_NUM; s++) begin : g_sync
    always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
        sync_q[s] <= '0;
      end else begin
        sync_q[s] <= {sync_q[s][SYNC_STAGES-2:0], pins[s]};
      end
    end

    // Level moves only once stages two and three agree
    always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
        level_q[s] <= 1'b0;
      end else if (sync_q[s][1] == sync_q[s][2]) begin
        level_q[s] <= sync_q[s][2];
      end
    end
  end

  // ---------------------------------------------------------------
  // Source selection and edge detect
  // ---------------------------------------------------------------
  // three-way source mux
  always_comb begin
    case (src_q)
      SRC_LOW_POWER: sel_level = level_q[0];
      SRC_EXT_REF:   sel_level = level_q[1];
      SRC_INT_REF:   sel_level = level_q[2];
      default:       sel_level = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= sel_level;
    end
  end

  assign tick_bus.src_edge = sel_level && !prev_q;
  assign tick_bus.ratio    = div_ratio(div_q);
  assign tick_bus.run      = (div_q != DIV_OFF);
  assign tick_bus.clear    = restart;

  tick_prescaler u_prescaler (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .bus     (tick_bus)
  );

  // ---------------------------------------------------------------
  // Write channel
  // ---------------------------------------------------------------
  assign o_awready = !aw_held_q;
  assign o_wready  = !w_held_q;
  assign wr_go     = aw_held_q && w_held_q && !bvalid_q;

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (i_awvalid && o_awready) begin
      aw_held_q <= 1'b1;
      aw_addr_q <= i_awaddr;
    end else if (wr_go) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      w_held_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (i_wvalid && o_wready) begin
      w_held_q <= 1'b1;
      w_data_q <= i_wdata;
      w_strb_q <= i_wstrb;
    end else if (wr_go) begin
      w_held_q <= 1'b0;
    end
  end

  // Address decode of the held write
  always_comb begin
    wr_limit = 1'b0;
    wr_ctrl  = 1'b0;
    wr_stat  = 1'b0;
    wr_hit   = 1'b1;
    if (aw_addr_q == OFS_COUNT) begin
      wr_hit = 1'b1;
    end else if (aw_addr_q == OFS_LIMIT) begin
      wr_limit = wr_go;
    end else if (aw_addr_q == OFS_CTRL) begin
      wr_ctrl = wr_go;
    end else if (aw_addr_q == OFS_STAT) begin
      wr_stat = wr_go;
    end else begin
      wr_hit = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (i_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign o_bvalid = bvalid_q;
  assign o_bresp  = bresp_q;

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  always_comb begin
    ctrl_word = '0;
    ctrl_word[CTRL_SRC_LSB +: SRC_W] = src_q;
    ctrl_word[CTRL_DIV_LSB +: DIV_W] = div_q;
    ctrl_word[CTRL_IEN_BIT]          = ien_q;
  end

  assign ctrl_new  = apply_strb(ctrl_word, w_data_q, w_strb_q);
  assign limit_new = apply_strb({{(DATA_W-CNT_W){1'b0}}, limit_q}, w_data_q, w_strb_q);
  assign stat_new  = apply_strb('0, w_data_q, w_strb_q);
  assign src_new   = source_e'(ctrl_new[CTRL_SRC_LSB +: SRC_W]);
  assign div_new   = ctrl_new[CTRL_DIV_LSB +: DIV_W];

  assign cfg_change = wr_ctrl && ((src_new != src_q) || (div_new != div_q));
  assign restart    = wr_limit || cfg_change;

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      limit_q <= LIMIT_RST;
    end else if (wr_limit) begin
      limit_q <= limit_new[CNT_W-1:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      src_q <= SRC_RST;
      div_q <= DIV_RST;
      ien_q <= 1'b0;
    end else if (wr_ctrl) begin
      src_q <= src_new;
      div_q <= div_new;
      ien_q <= ctrl_new[CTRL_IEN_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Main counter
  // ---------------------------------------------------------------
  // limit zero matches each pulse
  assign match = tick_bus.tick && (count_q == limit_q) && !restart;

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      count_q <= COUNT_RST;
    end else if (restart) begin
      count_q <= COUNT_RST;
    end else if (tick_bus.tick) begin
      count_q <= (count_q == limit_q) ? COUNT_RST : count_q + CNT_W'(1);
    end
  end

  // ---------------------------------------------------------------
  // Periodic flag and interrupt
  // ---------------------------------------------------------------
  assign flag_set = match;
  assign flag_clr = wr_stat && stat_new[STAT_FLG_BIT];

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_set || (flag_q && !flag_clr);
    end
  end

  assign o_irq = flag_q && ien_q;

  // ---------------------------------------------------------------
  // Read channel
  // ---------------------------------------------------------------
  assign o_arready = !rvalid_q;

  always_comb begin
    rd_word = '0;
    rd_hit  = 1'b1;
    if (i_araddr == OFS_COUNT) begin
      rd_word[CNT_W-1:0] = count_q;
    end else if (i_araddr == OFS_LIMIT) begin
      rd_word[CNT_W-1:0] = limit_q;
    end else if (i_araddr == OFS_CTRL) begin
      rd_word = ctrl_word;
    end else if (i_araddr == OFS_STAT) begin
      rd_word[STAT_FLG_BIT] = flag_q;
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      rvalid_q <= 1'b0;
      rresp_q  <= RESP_OKAY;
      rdata_q  <= '0;
    end else if (i_arvalid && o_arready) begin
      rvalid_q <= 1'b1;
      rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      rdata_q  <= rd_word;
    end else if (i_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign o_rvalid = rvalid_q;
  assign o_rresp  = rresp_q;
  assign o_rdata  = rdata_q;

endmodule

// ===== tb/periodic_tick_counter_monitor.sv
`timescale 1ns/1ps
module periodic_tick_counter_monitor
  import tick_pkg::*;
(
  input wire logic              i_clk,     // Clock
  input wire logic              i_rst_b,   // Reset, low
  input wire logic [ADDR_W-1:0] i_awaddr,  // Write address
  input wire logic              i_awvalid, // Write addr valid
  input wire logic              o_awready, // Write addr ready
  input wire logic              i_wvalid,  // Write data valid
  input wire logic              o_wready,  // Write data ready
  input wire logic [1:0]        o_bresp,   // Write response
  input wire logic              o_bvalid,  // Response valid
  input wire logic              i_bready,  // Response ready
  input wire logic [ADDR_W-1:0] i_araddr,  // Read address
  input wire logic              i_arvalid, // Read addr valid
  input wire logic              o_arready, // Read addr ready
  input wire logic [DATA_W-1:0] o_rdata,   // Read data
  input wire logic [1:0]        o_rresp,   // Read response
  input wire logic              o_rvalid,  // Read valid
  input wire logic              i_rready,  // Read ready
  input wire logic              o_irq      // Interrupt
);
  default clocking cb @(posedge i_clk); endclocking

  logic [ADDR_W-1:0] aw_q;
  logic [ADDR_W-1:0] ar_q;
  logic              ar_bad;

  assign ar_bad = !(i_araddr inside {OFS_COUNT, OFS_LIMIT, OFS_CTRL, OFS_STAT});

  always_ff @(posedge i_clk) begin
    if (i_awvalid && o_awready) begin
      aw_q <= i_awaddr;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_arvalid && o_arready) begin
      ar_q <= i_araddr;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  reset_quiet_a: assert property (!i_rst_b |=> !o_bvalid && !o_rvalid && !o_irq)
    else $error("outputs active after reset");
  write_answer_a: assert property (disable iff (!i_rst_b)
    i_awvalid && o_awready && i_wvalid && o_wready && !o_bvalid |-> ##[1:3] o_bvalid)
    else $error("write response missing");
  bresp_hold_a: assert property (disable iff (!i_rst_b)
    o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped");
  rdata_hold_a: assert property (disable iff (!i_rst_b)
    o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata) && $stable(o_rresp))
    else $error("read data dropped");
  read_answer_a: assert property (disable iff (!i_rst_b) i_arvalid && o_arready |=> o_rvalid)
    else $error("read answer late");
  ar_block_a: assert property (disable iff (!i_rst_b) o_rvalid |-> !o_arready)
    else $error("read address taken while busy");
  unmapped_err_a: assert property (disable iff (!i_rst_b)
    i_arvalid && o_arready && ar_bad |=> o_rresp == RESP_SLVERR)
    else $error("unmapped read not refused");
  count_width_a: assert property (disable iff (!i_rst_b)
    o_rvalid && ar_q == OFS_COUNT |-> o_rdata[31:8] == 24'h00_0000)
    else $error("count wider than eight bits");
  count_write_ok_a: assert property (disable iff (!i_rst_b)
    $rose(o_bvalid) && aw_q == OFS_COUNT |-> o_bresp == RESP_OKAY)
    else $error("count write refused");

  cover property (disable iff (!i_rst_b) o_bvalid && i_bready);
  cover property (disable iff (!i_rst_b) o_rvalid && i_rready);
  cover property (disable iff (!i_rst_b) $rose(o_irq));
endmodule

bind periodic_tick_counter periodic_tick_counter_monitor u_mon (
  .i_clk, .i_rst_b, .i_awaddr, .i_awvalid, .o_awready, .i_wvalid, .o_wready, .o_bresp,
  .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp,
  .o_rvalid, .i_rready, .o_irq
);

// ===== tb/periodic_tick_counter_tb.sv
`timescale 1ns/1ps
module periodic_tick_counter_tb;
  import tick_pkg::*;

  logic              i_clk = 0, i_rst_b = 0;
  logic [2:0]        src = 3'h0;
  logic [ADDR_W-1:0] i_awaddr = '0, i_araddr = '0;
  logic [DATA_W-1:0] i_wdata = '0, o_rdata;
  logic [STRB_W-1:0] i_wstrb = '0;
  logic              i_awvalid = 0, i_wvalid = 0, i_bready = 0, i_arvalid = 0, i_rready = 0;
  logic              o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq;
  logic [1:0]        o_bresp, o_rresp, rs;
  logic [DATA_W-1:0] rv;
  int                err_total = 0, n_compared = 0;

  always #12.5 i_clk = ~i_clk;

  periodic_tick_counter u_dut (
    .i_clk, .i_rst_b, .i_low_power_osc_clock(src[0]), .i_external_ref_clock(src[1]),
    .i_internal_ref_clock(src[2]), .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb,
    .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid,
    .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .o_irq
  );

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic end_of_test();
    if (err_total == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic guard(input int n);
    if (n >= 100) begin
      err_total++;
      $display("Error bus timeout expected answer seen none");
      end_of_test();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic aw_ok, w_ok;
    n = 0;
    aw_ok = 0;
    w_ok = 0;
    i_awaddr <= a;
    i_wdata <= d;
    i_wstrb <= 4'hF;
    i_awvalid <= 1;
    i_wvalid <= 1;
    i_bready <= 1;
    while (!(aw_ok && w_ok) && n < 100) begin
      @(posedge i_clk);
      n++;
      if (!aw_ok && o_awready === 1) begin
        aw_ok = 1;
        i_awvalid <= 0;
      end
      if (!w_ok && o_wready === 1) begin
        w_ok = 1;
        i_wvalid <= 0;
      end
    end
    guard(n);
    do begin
      @(posedge i_clk);
      n++;
    end while (o_bvalid !== 1 && n < 100);
    guard(n);
    i_bready <= 0;
    chk("bresp", {30'h0, o_bresp}, {30'h0, er});
    // Let an edge pass before the next request
    @(posedge i_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    i_araddr <= a;
    i_arvalid <= 1;
    i_rready <= 1;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_arready !== 1 && n < 100);
    i_arvalid <= 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_rvalid !== 1 && n < 100);
    guard(n);
    i_rready <= 0;
    chk("rresp", {30'h0, o_rresp}, {30'h0, er});
    if (er == RESP_OKAY) begin
      chk("rdata", o_rdata, ed);
    end
    // Let an edge pass before the next request
    @(posedge i_clk);
  endtask

  // Source pulses, slow against the clock
  task automatic pulse(input int p, input int k);
    repeat (k) begin
      src[p] <= 1;
      repeat (10) @(posedge i_clk);
      src[p] <= 0;
      repeat (10) @(posedge i_clk);
    end
  endtask

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (2) @(posedge i_clk);
    i_rst_b <= 1;
    @(posedge i_clk);
    // Reset values
    rd(OFS_COUNT, 32'h0, RESP_OKAY);
    rd(OFS_LIMIT, 32'h0, RESP_OKAY);
    rd(OFS_CTRL, 32'h0, RESP_OKAY);
    rd(OFS_STAT, 32'h0, RESP_OKAY);
    rd(8'h10, 32'h0, RESP_SLVERR);
    wr(8'h10, 32'h0, RESP_SLVERR);
    // Binary ratio two, limit three
    wr(OFS_CTRL, 32'h0000_0110, RESP_OKAY);
    wr(OFS_LIMIT, 32'h0000_0003, RESP_OKAY);
    pulse(0, 4);
    rd(OFS_COUNT, 32'h2, RESP_OKAY);
    wr(OFS_COUNT, 32'h0000_0055, RESP_OKAY);
    rd(OFS_COUNT, 32'h2, RESP_OKAY);
    wr(OFS_CTRL, 32'h0000_0110, RESP_OKAY);
    rd(OFS_COUNT, 32'h2, RESP_OKAY);
    // Limit write restarts prescaler and count
    pulse(0, 1);
    wr(OFS_LIMIT, 32'h0000_0003, RESP_OKAY);
    rd(OFS_COUNT, 32'h0, RESP_OKAY);
    pulse(0, 1);
    rd(OFS_COUNT, 32'h0, RESP_OKAY);
    pulse(0, 1);
    rd(OFS_COUNT, 32'h1, RESP_OKAY);
    // Source change restarts, only chosen source counts
    wr(OFS_CTRL, 32'h0000_0111, RESP_OKAY);
    rd(OFS_COUNT, 32'h0, RESP_OKAY);
    pulse(0, 2);
    rd(OFS_COUNT, 32'h0, RESP_OKAY);
    pulse(1, 2);
    rd(OFS_COUNT, 32'h1, RESP_OKAY);
    wr(OFS_CTRL, 32'h0000_0112, RESP_OKAY);
    pulse(2, 2);
    rd(OFS_COUNT, 32'h1, RESP_OKAY);
    // Limit zero flags every tick
    wr(OFS_LIMIT, 32'h0000_0000, RESP_OKAY);
    pulse(2, 2);
    rd(OFS_COUNT, 32'h0, RESP_OKAY);
    rd(OFS_STAT, 32'h1, RESP_OKAY);
    chk("irq", {31'h0, o_irq}, 32'h1);
    wr(OFS_STAT, 32'h0000_0001, RESP_OKAY);
    rd(OFS_STAT, 32'h0, RESP_OKAY);
    chk("irq", {31'h0, o_irq}, 32'h0);
    // Wrap at limit one
    wr(OFS_LIMIT, 32'h0000_0001, RESP_OKAY);
    pulse(2, 4);
    rd(OFS_COUNT, 32'h0, RESP_OKAY);
    rd(OFS_STAT, 32'h1, RESP_OKAY);
    wr(OFS_STAT, 32'h0000_0001, RESP_OKAY);
    // Decimal ratio ten
    wr(OFS_CTRL, 32'h0000_0192, RESP_OKAY);
    wr(OFS_LIMIT, 32'h0000_0010, RESP_OKAY);
    pulse(2, 9);
    rd(OFS_COUNT, 32'h0, RESP_OKAY);
    pulse(2, 1);
    rd(OFS_COUNT, 32'h1, RESP_OKAY);
    // No source selected, ratio one: nothing counts
    wr(OFS_CTRL, 32'h0000_0183, RESP_OKAY);
    pulse(0, 1);
    pulse(1, 1);
    pulse(2, 1);
    rd(OFS_COUNT, 32'h0, RESP_OKAY);
    // Prescaler off
    wr(OFS_CTRL, 32'h0000_0002, RESP_OKAY);
    pulse(2, 4);
    rd(OFS_COUNT, 32'h0, RESP_OKAY);
    // Flag without enable raises no interrupt
    wr(OFS_LIMIT, 32'h0000_0000, RESP_OKAY);
    wr(OFS_CTRL, 32'h0000_0012, RESP_OKAY);
    pulse(2, 2);
    rd(OFS_STAT, 32'h1, RESP_OKAY);
    chk("irq", {31'h0, o_irq}, 32'h0);
    // Reset in mid-run restores defaults
    wr(OFS_LIMIT, 32'h0000_0005, RESP_OKAY);
    i_rst_b <= 0;
    repeat (2) @(posedge i_clk);
    i_rst_b <= 1;
    @(posedge i_clk);
    rd(OFS_LIMIT, 32'h0, RESP_OKAY);
    rd(OFS_CTRL, 32'h0, RESP_OKAY);
    rd(OFS_STAT, 32'h0, RESP_OKAY);
    rd(OFS_COUNT, 32'h0, RESP_OKAY);
    chk("irq", {31'h0, o_irq}, 32'h0);
    end_of_test();
  end
endmodule
